// *** pkg/sccd_pkg.sv ***
package sccd_pkg;
    // apb register byte offsets
    localparam logic [7:0] RUN_CFG_OFS = 8'h00;
    localparam logic [7:0] DSLP_CFG_OFS = 8'h04;
    localparam logic [7:0] GPIO_SEL_OFS = 8'h08;
    localparam logic [7:0] MODE_CTL_OFS = 8'h0C;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    localparam logic [7:0] RAW_INT_OFS = 8'h14;
    localparam logic [7:0] INT_MASK_OFS = 8'h18;
    localparam logic [7:0] FLASH_SIZE_OFS = 8'h1C;
    // run config fields
    localparam int DIV_W = 6;
    localparam int XTAL_W = 5;
    localparam int SRC_W = 3;
    localparam int RUN_DIV_LSB = 0;
    localparam int RUN_PLL_BIT = 6;
    localparam int XTAL_LSB = 7;
    localparam int RUN_SRC_LSB = 12;
    localparam int INT_OFF_BIT = 15;
    localparam int MAIN_OFF_BIT = 16;
    localparam int RUN_CFG_W = 17;
    localparam logic [16:0] RUN_CFG_RST = 17'h0_0000;
    // deep-sleep config fields
    localparam int DSLP_DIV_LSB = 0;
    localparam int DSLP_SRC_LSB = 6;
    localparam int PIOSC_PD_BIT = 8;
    localparam int DSLP_CFG_W = 9;
    localparam logic [8:0] DSLP_CFG_RST = 9'h000;
    // mode control fields
    localparam int SLEEP_REQ_BIT = 0;
    localparam int DEEP_REQ_BIT = 1;
    localparam int GATING_BIT = 2;
    localparam int PERIPH_DS_LSB = 8;
    localparam int N_PERIPH = 8;
    localparam int N_GPIO = 8;
    // status fields
    localparam int LOCK_LIVE_BIT = 0;
    localparam int PLL_SEL_BIT = 1;
    localparam int MODE_LSB = 2;
    // event bits in raw status and mask
    localparam int INT_PLL_LOCK = 0;
    localparam int INT_MOSC_FAIL = 1;
    localparam int INT_IOSC_FAIL = 2;
    localparam int N_INT = 3;
    // crystal codes: 0 is 1 MHz ... 22 is 16.3 MHz
    localparam logic [4:0] XTAL_3_57 = 5'h04;
    localparam logic [4:0] XTAL_MAX = 5'h16;
    // oscillator activity strobes
    localparam int TK_MAIN = 0;
    localparam int TK_INT = 1;
    localparam int TK_EXT32 = 2;
    localparam int TK_INT30 = 3;
    localparam int TK_PLL = 4;
    localparam int N_TICK = 5;
    // flash size in kbytes, read only
    localparam logic [15:0] FLASH_KB_RST = 16'h0100;
    typedef enum logic [2:0] {
        SELECT_MAIN_OSCILLATOR, SELECT_INTERNAL_OSCILLATOR, SELECT_INTERNAL_DIV_FOUR,
        SELECT_EXTERNAL_32K, SELECT_INTERNAL_30K
    } sccd_src_t;
    typedef enum logic [1:0] {
        DEEP_SLEEP_MAIN_SOURCE, DEEP_SLEEP_INTERNAL_SOURCE,
        DEEP_SLEEP_INTERNAL_30K_SOURCE, DEEP_SLEEP_EXTERNAL_32K_SOURCE
    } sccd_ds_src_t;
    typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_DEEP} sccd_mode_t;
endpackage

// *** pkg/sccd_div_if.sv ***
`timescale 1ns/1ps
interface sccd_div_if;
    import sccd_pkg::*;
    logic tick;
    logic [DIV_W-1:0] ratio;
    logic pulse;
    modport ctrl (output tick, output ratio, input pulse);
    modport div (input tick, input ratio, output pulse);
endinterface

// *** hw/sccd_sync.sv ***
`timescale 1ns/1ps
module sccd_sync #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // asynchronous levels in, synchronised out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // two stages; only the second is visible outside
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;
endmodule

// *** hw/sccd_div.sv ***
`timescale 1ns/1ps
module sccd_div
    import sccd_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // source strobe in, divided strobe out
    sccd_div_if.div dv
);
    logic [DIV_W-1:0] cnt_q, cnt_d;
    logic pulse_q, pulse_d;

    // count strobes; code n divides by n+1
    always_comb
    begin
        cnt_d = cnt_q;
        pulse_d = 1'b0;
        if (dv.tick)
        begin
            // >= so a ratio lowered mid-count cannot overrun
            if (cnt_q >= dv.ratio)
            begin
                cnt_d = '0;
                pulse_d = 1'b1;
            end
            else
            begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= '0;
            pulse_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            pulse_q <= pulse_d;
        end
    end

    assign dv.pulse = pulse_q;

    sequence s_last_tick;
        dv.tick && (cnt_q >= dv.ratio);
    endsequence

    property p_div_fire;
        @(posedge pclk) disable iff (!presetn)
        s_last_tick |=> pulse_q ##1 (cnt_q == '0 || $past(dv.tick));
    endproperty
    a_div_fire: assert property (p_div_fire) else $error("divider missed its output strobe");

    property p_div_quiet;
        @(posedge pclk) disable iff (!presetn)
        (!dv.tick || cnt_q < dv.ratio) |=> !pulse_q;
    endproperty
    a_div_quiet: assert property (p_div_quiet) else $error("divider strobe without full count");
endmodule

// *** hw/sccd_top.sv ***
// Operation
// - run divider ratio one to sixty-four
// - pll or direct oscillator, exactly one
// - crystal code selects supported crystal frequency
// - five run oscillator sources selectable
// - external 32k only with hibernation enabled
// - separate internal and main oscillator off
// - never switch off the active oscillator
// - pll lock sets sticky flag, software polls
// - deep-sleep divider one to sixty-four
// - deep-sleep source main, internal, 30k, 32k
// - precision oscillator powers down in deep sleep unless needed
// - deep sleep stops cpu, peripherals gated
// - per-port gpio ahb selection ports a-h
// - clearing selection returns port to apb
// - readable flash size indication
// - enabled event wakes from sleep modes
// - events maskable, pending until cleared
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
module sccd_top
    import sccd_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // asynchronous oscillator strobes and analog flags
    input wire logic [N_TICK-1:0] osc_tick,
    input wire logic pll_lock,
    input wire logic mosc_fail,
    input wire logic iosc_fail,
    // same-clock inputs from neighbours
    input wire logic hib_enabled,
    input wire logic wake_irq,
    // clock enables
    output logic sys_clk_en,
    output logic cpu_clk_en,
    output logic [N_PERIPH-1:0] periph_clk_en,
    // oscillator and pll controls
    output logic source_via_pll,
    output logic source_direct_oscillator,
    output logic pll_power_en,
    output logic [XTAL_W-1:0] crystal_frequency_code,
    output logic main_oscillator_off,
    output logic internal_oscillator_off,
    output logic precision_osc_powerdown,
    // bus attachment and mode
    output logic [N_GPIO-1:0] gpio_ahb_select,
    output logic [1:0] power_mode
);
    logic [N_TICK+N_INT-1:0] sync_s, prev_q, rise;
    logic [1:0] cnt4_q, cnt4_d;
    logic int4_tick, run_osc_tick, ds_tick, lock_live, deep;
    logic [RUN_CFG_W-1:0] run_cfg_q, run_cfg_d;
    logic [DSLP_CFG_W-1:0] dslp_cfg_q, dslp_cfg_d;
    logic [N_GPIO-1:0] gpio_q, gpio_d;
    logic [N_PERIPH-1:0] pds_q, pds_d, periph_q, periph_d;
    logic gate_q, gate_d;
    logic [N_INT-1:0] ris_q, ris_d, mask_q, mask_d;
    sccd_mode_t mode_q, mode_d;
    logic pll_sel_q, pll_sel_d, pll_pwr_q, pll_pwr_d, sys_q, cpu_q, cpu_d;
    logic main_off_q, main_off_d, int_off_q, int_off_d, piosc_q, piosc_d;
    logic [31:0] prdata_q, prdata_d, rd;
    logic pready_q, pslverr_q, pslverr_d, hit;
    logic setup, wr, wake, act_main, act_int, xtal_ok;
    logic [SRC_W-1:0] run_src, new_src;
    logic [1:0] ds_src;

    sccd_div_if u_dif ();

    // analog flags and strobes are asynchronous
    sccd_sync #(.W(N_TICK + N_INT)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({iosc_fail, mosc_fail, pll_lock, osc_tick}),
        .q(sync_s)
    );

    sccd_div u_div (
        .pclk(pclk),
        .presetn(presetn),
        .dv(u_dif)
    );

    // edge detect behind the synchroniser
    assign rise = sync_s & ~prev_q;
    assign lock_live = sync_s[N_TICK + INT_PLL_LOCK];
    assign deep = (mode_q == MODE_DEEP);
    assign setup = psel && !penable;
    assign wr = psel && penable && pready_q && pwrite;
    assign run_src = run_cfg_q[RUN_SRC_LSB +: SRC_W];
    assign ds_src = dslp_cfg_q[DSLP_SRC_LSB +: 2];
    assign new_src = pwdata[RUN_SRC_LSB +: SRC_W];
    // pll only with a crystal above 3.57 MHz
    assign xtal_ok = (run_cfg_q[XTAL_LSB +: XTAL_W] > XTAL_3_57)
        && (run_cfg_q[XTAL_LSB +: XTAL_W] <= XTAL_MAX);
    assign int4_tick = rise[TK_INT] && (cnt4_q == 2'h3);
    assign wake = (|(ris_q & mask_q)) || wake_irq;

    // run source strobe, internal/4 from a 2-bit count
    always_comb
    begin
        cnt4_d = rise[TK_INT] ? cnt4_q + 2'h1 : cnt4_q;
        case (run_src)
            SELECT_INTERNAL_OSCILLATOR: run_osc_tick = rise[TK_INT];
            SELECT_INTERNAL_DIV_FOUR: run_osc_tick = int4_tick;
            SELECT_EXTERNAL_32K: run_osc_tick = rise[TK_EXT32];
            SELECT_INTERNAL_30K: run_osc_tick = rise[TK_INT30];
            default: run_osc_tick = rise[TK_MAIN];
        endcase
        case (ds_src)
            DEEP_SLEEP_INTERNAL_SOURCE: ds_tick = rise[TK_INT];
            DEEP_SLEEP_INTERNAL_30K_SOURCE: ds_tick = rise[TK_INT30];
            DEEP_SLEEP_EXTERNAL_32K_SOURCE: ds_tick = rise[TK_EXT32];
            default: ds_tick = rise[TK_MAIN];
        endcase
    end

    // divider input: deep sleep never runs from the pll
    // deep-sleep ratio used while in deep sleep
    assign u_dif.tick = deep ? ds_tick : (pll_sel_q ? rise[TK_PLL] : run_osc_tick);
    assign u_dif.ratio = deep ? dslp_cfg_q[DSLP_DIV_LSB +: DIV_W]
        : run_cfg_q[RUN_DIV_LSB +: DIV_W];

    // apb writes and register state
    always_comb
    begin
        run_cfg_d = run_cfg_q;
        dslp_cfg_d = dslp_cfg_q;
        gpio_d = gpio_q;
        pds_d = pds_q;
        gate_d = gate_q;
        mask_d = mask_q;
        ris_d = ris_q;
        if (wr && paddr == RUN_CFG_OFS)
        begin
            // divider, pll use, crystal, source, off bits
            run_cfg_d = pwdata[RUN_CFG_W-1:0];
            // refuse 32k without hibernation; bad codes too
            if (new_src > SELECT_INTERNAL_30K || (new_src == SELECT_EXTERNAL_32K && !hib_enabled))
                run_cfg_d[RUN_SRC_LSB +: SRC_W] = run_src;
        end
        else if (wr && paddr == DSLP_CFG_OFS)
        begin
            dslp_cfg_d = pwdata[DSLP_CFG_W-1:0];
            // 32k deep-sleep source only with hibernation
            if (pwdata[DSLP_SRC_LSB +: 2] == DEEP_SLEEP_EXTERNAL_32K_SOURCE && !hib_enabled)
                dslp_cfg_d[DSLP_SRC_LSB +: 2] = ds_src;
        end
        else if (wr && paddr == GPIO_SEL_OFS)
        begin
            // ahb when set, apb when clear
            gpio_d = pwdata[N_GPIO-1:0];
        end
        else if (wr && paddr == MODE_CTL_OFS)
        begin
            gate_d = pwdata[GATING_BIT];
            pds_d = pwdata[PERIPH_DS_LSB +: N_PERIPH];
        end
        else if (wr && paddr == INT_MASK_OFS)
        begin
            mask_d = pwdata[N_INT-1:0];
        end
        else if (wr && paddr == RAW_INT_OFS)
        begin
            // write one to clear
            ris_d = ris_q & ~pwdata[N_INT-1:0];
        end
        // new events win over a clear in the same cycle
        ris_d = ris_d | rise[N_TICK +: N_INT];
    end

    // power mode; commands only taken in run mode
    always_comb
    begin
        mode_d = mode_q;
        case (mode_q)
            MODE_RUN:
            begin
                if (wr && paddr == MODE_CTL_OFS && pwdata[DEEP_REQ_BIT])
                    mode_d = MODE_DEEP;
                else if (wr && paddr == MODE_CTL_OFS && pwdata[SLEEP_REQ_BIT])
                    mode_d = MODE_SLEEP;
            end
            default:
            begin
                // any enabled event returns to run
                if (wake)
                    mode_d = MODE_RUN;
            end
        endcase
    end

    // clock selection and oscillator controls
    always_comb
    begin
        // stay on the oscillator until lock is seen
        pll_sel_d = run_cfg_q[RUN_PLL_BIT] && lock_live && xtal_ok && !deep;
        pll_pwr_d = run_cfg_q[RUN_PLL_BIT] && xtal_ok && !deep;
        act_main = deep ? (ds_src == DEEP_SLEEP_MAIN_SOURCE) : (run_src == SELECT_MAIN_OSCILLATOR);
        act_int = deep ? (ds_src == DEEP_SLEEP_INTERNAL_SOURCE)
            : (run_src == SELECT_INTERNAL_OSCILLATOR || run_src == SELECT_INTERNAL_DIV_FOUR);
        // off requests, masked for the active one
        main_off_d = run_cfg_q[MAIN_OFF_BIT] && !act_main;
        int_off_d = run_cfg_q[INT_OFF_BIT] && !act_int;
        // kept on when deep sleep runs from it
        piosc_d = deep && dslp_cfg_q[PIOSC_PD_BIT] && !act_int;
        // cpu stopped outside run; gating picks peripherals
        cpu_d = u_dif.pulse && (mode_q == MODE_RUN);
        periph_d = {N_PERIPH{u_dif.pulse}} & ({N_PERIPH{!deep || !gate_q}} | pds_q);
    end

    // read mux, taken in the setup cycle
    always_comb
    begin
        rd = '0;
        hit = 1'b1;
        if (paddr == RUN_CFG_OFS)
            rd = 32'(run_cfg_q);
        else if (paddr == DSLP_CFG_OFS)
            rd = 32'(dslp_cfg_q);
        else if (paddr == GPIO_SEL_OFS)
            rd = 32'(gpio_q);
        else if (paddr == MODE_CTL_OFS)
            rd = 32'({pds_q, 5'h00, gate_q, 2'h0});
        else if (paddr == STATUS_OFS)
            // live lock below the pll selection and the mode
            rd = 32'({mode_q, pll_sel_q, lock_live});
        else if (paddr == INT_MASK_OFS)
            rd = 32'(mask_q);
        else if (paddr == RAW_INT_OFS)
            rd = 32'(ris_q);
        else if (paddr == FLASH_SIZE_OFS)
            // size in kbytes; bytes = value * 1024
            rd = 32'(FLASH_KB_RST);
        else
            hit = 1'b0;
        prdata_d = (setup && !pwrite) ? rd : 32'h0000_0000;
        pslverr_d = setup && !hit;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_q <= '0;
            cnt4_q <= 2'h0;
            run_cfg_q <= RUN_CFG_RST;
            dslp_cfg_q <= DSLP_CFG_RST;
            gpio_q <= '0;
            pds_q <= '0;
            gate_q <= 1'b0;
            mask_q <= '0;
            ris_q <= '0;
            mode_q <= MODE_RUN;
            pll_sel_q <= 1'b0;
            pll_pwr_q <= 1'b0;
            sys_q <= 1'b0;
            cpu_q <= 1'b0;
            periph_q <= '0;
            main_off_q <= 1'b0;
            int_off_q <= 1'b0;
            piosc_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            prev_q <= sync_s;
            cnt4_q <= cnt4_d;
            run_cfg_q <= run_cfg_d;
            dslp_cfg_q <= dslp_cfg_d;
            gpio_q <= gpio_d;
            pds_q <= pds_d;
            gate_q <= gate_d;
            mask_q <= mask_d;
            ris_q <= ris_d;
            mode_q <= mode_d;
            pll_sel_q <= pll_sel_d;
            pll_pwr_q <= pll_pwr_d;
            sys_q <= u_dif.pulse;
            cpu_q <= cpu_d;
            periph_q <= periph_d;
            main_off_q <= main_off_d;
            int_off_q <= int_off_d;
            piosc_q <= piosc_d;
            prdata_q <= prdata_d;
            pready_q <= setup;
            pslverr_q <= pslverr_d;
        end
    end

    // outputs from flops; the direct select is the inverted pll selection
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign sys_clk_en = sys_q;
    assign cpu_clk_en = cpu_q;
    assign periph_clk_en = periph_q;
    assign source_via_pll = pll_sel_q;
    assign source_direct_oscillator = !pll_sel_q;
    assign pll_power_en = pll_pwr_q;
    assign crystal_frequency_code = run_cfg_q[XTAL_LSB +: XTAL_W];
    assign main_oscillator_off = main_off_q;
    assign internal_oscillator_off = int_off_q;
    assign precision_osc_powerdown = piosc_q;
    assign gpio_ahb_select = gpio_q;
    assign power_mode = mode_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_pll_locked;
        !lock_live |=> !pll_sel_q;
    endproperty
    a_pll_locked: assert property (p_pll_locked) else $error("pll selected without lock");

    property p_one_source;
        pll_sel_q |-> $past(run_cfg_q[RUN_PLL_BIT]) && !deep || $past(deep) != deep;
    endproperty
    a_one_source: assert property (p_one_source) else $error("pll selected while not configured");

    property p_keep_main;
        act_main |=> !main_off_q || $past(mode_q) != mode_q || $past(run_src) != run_src;
    endproperty
    a_keep_main: assert property (p_keep_main) else $error("active main oscillator turned off");

    property p_keep_int;
        (act_int && $stable(mode_q) && $stable(run_cfg_q)) |=> !int_off_q;
    endproperty
    a_keep_int: assert property (p_keep_int) else $error("active internal oscillator turned off");

    property p_ext32_guard;
        (wr && paddr == RUN_CFG_OFS && new_src == SELECT_EXTERNAL_32K && !hib_enabled)
            |=> $stable(run_src);
    endproperty
    a_ext32_guard: assert property (p_ext32_guard) else $error("32k chosen without hibernation");

    property p_lock_flag;
        rise[N_TICK + INT_PLL_LOCK] |=> ris_q[INT_PLL_LOCK] ##1 (ris_q[INT_PLL_LOCK] || $past(wr));
    endproperty
    a_lock_flag: assert property (p_lock_flag) else $error("lock event not held pending");

    property p_pending;
        ris_q[INT_PLL_LOCK] && !(wr && paddr == RAW_INT_OFS && pwdata[INT_PLL_LOCK])
            |=> ris_q[INT_PLL_LOCK];
    endproperty
    a_pending: assert property (p_pending) else $error("pending event lost without clear");

    sequence s_asleep_wake;
        mode_q != MODE_RUN && wake;
    endsequence

    property p_wake;
        s_asleep_wake |=> mode_q == MODE_RUN ##1 !cpu_q || mode_q == MODE_RUN;
    endproperty
    a_wake: assert property (p_wake) else $error("enabled event did not wake");

    property p_cpu_stop;
        cpu_q |-> $past(mode_q) == MODE_RUN && sys_q;
    endproperty
    a_cpu_stop: assert property (p_cpu_stop) else $error("cpu clocked outside run mode");

    property p_piosc;
        precision_osc_powerdown |-> $past(deep) && !$past(act_int);
    endproperty
    a_piosc: assert property (p_piosc) else $error("needed precision oscillator powered down");

    property p_gpio_apb;
        (wr && paddr == GPIO_SEL_OFS && !pwdata[0]) |=> !gpio_ahb_select[0];
    endproperty
    a_gpio_apb: assert property (p_gpio_apb) else $error("port a did not return to apb");
endmodule

// *** verif/sccd_top_test.sv ***
`timescale 1ns/1ps
module sccd_top_test
    import sccd_pkg::*;
    ;
    // bench-driven stimulus, every input starts defined
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [N_TICK-1:0] osc_tick = '0;
    logic pll_lock = 1'b0;
    logic mosc_fail = 1'b0;
    logic iosc_fail = 1'b0;
    logic hib_enabled = 1'b0;
    logic wake_irq = 1'b0;
    logic [1:0] tk = 2'b00;
    // design outputs
    logic [31:0] prdata;
    logic pready, pslverr, sys_clk_en, cpu_clk_en, source_via_pll, source_direct_oscillator;
    logic pll_power_en, main_oscillator_off, internal_oscillator_off, precision_osc_powerdown;
    logic [N_PERIPH-1:0] periph_clk_en;
    logic [XTAL_W-1:0] crystal_frequency_code;
    logic [N_GPIO-1:0] gpio_ahb_select;
    logic [1:0] power_mode;
    // readback model, one word per register
    logic [31:0] mdl [8];
    int errors = 0;
    int cmp_count = 0;
    integer seed = 32'h8f39_6df9;

    sccd_top i_sccd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_tick(osc_tick), .pll_lock(pll_lock), .mosc_fail(mosc_fail),
        .iosc_fail(iosc_fail), .hib_enabled(hib_enabled), .wake_irq(wake_irq),
        .sys_clk_en(sys_clk_en), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
        .source_via_pll(source_via_pll), .source_direct_oscillator(source_direct_oscillator),
        .pll_power_en(pll_power_en), .crystal_frequency_code(crystal_frequency_code),
        .main_oscillator_off(main_oscillator_off),
        .internal_oscillator_off(internal_oscillator_off),
        .precision_osc_powerdown(precision_osc_powerdown),
        .gpio_ahb_select(gpio_ahb_select), .power_mode(power_mode));

    // 8 ns clock
    initial forever #4 pclk = ~pclk;
    // every source ticks once per four cycles, so a ratio n shows as 4n cycles
    always @(posedge pclk)
    begin
        tk <= tk + 2'd1;
        osc_tick <= {N_TICK{tk[1]}};
    end

    task automatic give_verdict();
        if (errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic gap(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16)
        begin
            errors++;
            give_verdict();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // writable bits as seen on readback
    function automatic logic [31:0] wmask(input int i);
        case (i)
            0: return 32'h0001_ffff;
            1: return 32'h0000_01ff;
            2: return 32'h0000_00ff;
            3: return 32'h0000_ff04;
            6: return 32'h0000_0007;
            default: return 32'h0000_0000;
        endcase
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        if (wmask(a[4:2]) != 0)
            mdl[a[4:2]] = d & wmask(a[4:2]);
        if (a == RAW_INT_OFS)
            mdl[5] = mdl[5] & ~d;
    endtask

    task automatic rd(input logic [7:0] a);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk("read data", r, mdl[a[4:2]]);
        chk("slave error", {31'h0, e}, 32'h0);
    endtask

    // measure the spacing of system enables once the divider has settled
    task automatic period(input int exp);
        int n;
        for (int k = 0; k < 3; k++)
        begin
            n = 0;
            do
            begin
                @(posedge pclk);
                n++;
            end while (sys_clk_en !== 1'b1 && n < 1000);
            if (n >= 1000)
            begin
                errors++;
                give_verdict();
            end
        end
        chk("tick spacing", 32'(n), 32'(exp));
    endtask

    initial
    begin
        logic [31:0] r;
        logic e;
        logic [5:0] c;
        int pulses;
        foreach (mdl[i])
            mdl[i] = 32'h0000_0000;
        mdl[7] = {16'h0000, FLASH_KB_RST};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        gap(2);
        chk("direct", {31'h0, source_direct_oscillator}, 32'h1);
        for (int i = 0; i < 8; i++)
            rd(8'(i * 4));
        apb(1'b0, 8'h20, 32'h0000_0000, r, e);
        chk("unmapped error", {31'h0, e}, 32'h1);
        chk("unmapped data", r, 32'h0);
        wr(FLASH_SIZE_OFS, 32'hffff_ffff);
        rd(FLASH_SIZE_OFS);
        r = $random(seed);
        wr(GPIO_SEL_OFS, r);
        gap(2);
        chk("ahb select", {24'h0, gpio_ahb_select}, r & 32'h0000_00ff);
        wr(GPIO_SEL_OFS, 32'h0000_0000);
        gap(2);
        chk("ahb cleared", {24'h0, gpio_ahb_select}, 32'h0);
        // divider boundaries and one random ratio
        for (int k = 0; k < 3; k++)
        begin
            c = (k == 0) ? 6'd0 : (k == 1) ? 6'd63 : 6'($random(seed));
            wr(RUN_CFG_OFS, {26'h0, c});
            period((int'(c) + 1) * 4);
        end
        // deep sleep with its own divider and precision powerdown
        c = 6'($random(seed)) & 6'h07;
        wr(DSLP_CFG_OFS, 32'h0000_0100 | c);
        wr(MODE_CTL_OFS, 32'h0000_0002);
        gap(4);
        chk("deep mode", {30'h0, power_mode}, 32'(MODE_DEEP));
        chk("piosc down", {31'h0, precision_osc_powerdown}, 32'h1);
        period((int'(c) + 1) * 4);
        pulses = 0;
        repeat (64)
        begin
            @(posedge pclk);
            pulses += (cpu_clk_en === 1'b1) + (periph_clk_en !== {N_PERIPH{sys_clk_en}});
        end
        chk("cpu stopped, peripherals run", 32'(pulses), 32'h0);
        wr(DSLP_CFG_OFS, 32'h0000_0140);
        gap(4);
        chk("piosc needed", {31'h0, precision_osc_powerdown}, 32'h0);
        wake_irq <= 1'b1;
        gap(3);
        chk("woken", {30'h0, power_mode}, 32'(MODE_RUN));
        wake_irq <= 1'b0;
        // lock event, pll selection and crystal limit
        pll_lock <= 1'b1;
        gap(8);
        mdl[5] = 32'h0000_0001;
        rd(RAW_INT_OFS);
        wr(RUN_CFG_OFS, 32'h0000_0040 | (32'(XTAL_3_57) << 7));
        gap(4);
        chk("pll refused", {31'h0, source_via_pll}, 32'h0);
        chk("pll power off", {31'h0, pll_power_en}, 32'h0);
        chk("direct kept", {31'h0, source_direct_oscillator}, 32'h1);
        wr(RUN_CFG_OFS, 32'h0000_0040 | ((32'(XTAL_3_57) + 1) << 7));
        gap(4);
        chk("pll used", {31'h0, source_via_pll}, 32'h1);
        chk("pll power", {31'h0, pll_power_en}, 32'h1);
        chk("direct off", {31'h0, source_direct_oscillator}, 32'h0);
        chk("crystal", {27'h0, crystal_frequency_code}, 32'(XTAL_3_57) + 1);
        pll_lock <= 1'b0;
        {iosc_fail, mosc_fail} <= 2'b11;
        gap(6);
        chk("pll dropped", {31'h0, source_via_pll}, 32'h0);
        mdl[5] = 32'h0000_0007;
        wr(RAW_INT_OFS, 32'h0000_0001);
        rd(RAW_INT_OFS);
        // unmasked lock event wakes from sleep
        wr(INT_MASK_OFS, 32'h0000_0001);
        wr(MODE_CTL_OFS, 32'h0000_0001);
        gap(3);
        chk("sleep mode", {30'h0, power_mode}, 32'(MODE_SLEEP));
        pll_lock <= 1'b1;
        gap(8);
        chk("event wake", {30'h0, power_mode}, 32'(MODE_RUN));
        // oscillator off requests against the active one
        wr(RUN_CFG_OFS, 32'h0001_8000);
        gap(3);
        chk("main kept", {31'h0, main_oscillator_off}, 32'h0);
        chk("int off", {31'h0, internal_oscillator_off}, 32'h1);
        wr(RUN_CFG_OFS, 32'h0001_9000);
        gap(3);
        chk("main off", {31'h0, main_oscillator_off}, 32'h1);
        chk("int kept", {31'h0, internal_oscillator_off}, 32'h0);
        // external 32k needs hibernation enabled
        wr(RUN_CFG_OFS, 32'h0000_3000);
        mdl[0][14:12] = 3'd1;
        rd(RUN_CFG_OFS);
        hib_enabled <= 1'b1;
        wr(RUN_CFG_OFS, 32'h0000_3000);
        rd(RUN_CFG_OFS);
        give_verdict();
    end
endmodule
